/* File: inc/ebt_pkg.sv */
// package for the dual 8-bit timer with pwm
// assumes one 125 MHz clock, synchronous active-high reset, 8-bit bus
package ebt_pkg;

    // ========================================================================
    // bus and register map
    localparam int AW = 4;
    localparam int DW = 8;
    localparam int NTMR = 2;
    localparam int NSRC = 7;
    localparam int NPIN = 3;
    localparam logic [1:0] REG_CTL = 2'h0;
    localparam logic [1:0] REG_SCL = 2'h1;
    localparam logic [1:0] REG_CNT = 2'h2;
    localparam logic [1:0] REG_BND = 2'h3;
    localparam logic [3:0] OFS_TMR0 = 4'h0;
    localparam logic [3:0] OFS_TMR1 = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'h9;

    // ========================================================================
    // field positions
    localparam int CTL_SRC_MSB = 7;
    localparam int CTL_SRC_LSB = 4;
    localparam int CTL_OSEL_MSB = 3;
    localparam int CTL_OSEL_LSB = 2;
    localparam int CTL_MODE_BIT = 1;
    localparam int SCL_RES_BIT = 7;
    localparam int SCL_PRE_MSB = 6;
    localparam int SCL_PRE_LSB = 5;
    localparam int SCL_DIV_MSB = 4;
    localparam logic [7:0] CTL_RW_MASK = 8'hfe;

    // ========================================================================
    // clock source codes; codes from SRC_FIRST_EXT map to src_in index
    localparam logic [3:0] SRC_STOP = 4'h0;
    localparam logic [3:0] SRC_SYS = 4'h1;
    localparam logic [3:0] SRC_FIRST_EXT = 4'h2;
    localparam logic [3:0] SRC_LAST_EXT = 4'h8;

    // ========================================================================
    // counts
    localparam logic [5:0] PRE_LIM [4] = '{6'h00, 6'h03, 6'h0f, 6'h3f};
    localparam logic [7:0] PWM8_TOP = 8'hff;
    localparam logic [7:0] PWM6_TOP = 8'h3f;

    // ========================================================================
    // carriers and state
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } ebt_bus_req_type;

    typedef struct packed {
        logic [7:0] ctl;
        logic [7:0] scl;
        logic [7:0] bnd;
        logic act_mode;
        logic act_res;
        logic [1:0] act_osel;
        logic [7:0] act_bnd;
        logic [7:0] cnt;
        logic ld_pend;
        logic [7:0] ld_val;
        logic [5:0] pre;
        logic [4:0] sc;
        logic wout;
    } ebt_tmr_type;

    typedef struct packed {
        logic [NSRC-1:0] s1;
        logic [NSRC-1:0] s2;
        logic [NSRC-1:0] s3;
        logic [NSRC-1:0] filt;
        ebt_tmr_type [NTMR-1:0] tm;
        logic [NTMR-1:0] stat;
        logic [NTMR-1:0] mask;
        logic [DW-1:0] rdata;
    } ebt_state_type;

    localparam ebt_state_type ST_RST = '0;

endpackage

/* File: src/ebt_timer.sv */
// two identical 8-bit up-counting timers with period and pwm modes
// assumes a same-clock bus master and asynchronous clock source inputs
// Operation
// RULE1: four-bit control field picks the timer clock source.
// RULE2: two-bit control field routes the timer output to one of three pins.
// RULE3: a selected output pin is driven regardless of its direction bit.
// RULE4: prescaler divides the selected clock by 1, 4, 16 or 64.
// RULE5: scaler divides further by field value plus one, giving the tick.
// RULE6: counter counts up only; software writes and reads it back.
// RULE7: counter clears to zero when it reaches the bound.
// RULE8: bound is an unsigned count used for period and duty.
// RULE9: two modes exist, period mode and pwm mode.
// RULE10: pwm mode offers 6-bit or 8-bit resolution.
// RULE11: period mode gives a 50 percent square wave.
// RULE12: mode bit 1 with resolution bit 0 gives 256-tick pwm.
// RULE13: a second identical timer drives its own three pins.
// RULE14: 8-bit pwm is high bound+1 of 256 ticks; 255 stays high.
// RULE15: mode and resolution bits both 1 give 64-tick pwm.
// RULE16: period mode toggles output and raises the event at each wrap.
// RULE17: register writes take effect on the next tick without glitches; the source, prescale and divider fields act at once.
`timescale 1ns/10ps

module ebt_timer
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire ebt_bus_req_type bus_req,
    output logic [DW-1:0] bus_rdata,
    input wire logic [NSRC-1:0] src_in,
    output logic [NTMR*NPIN-1:0] tmr_pin_o,
    output logic [NTMR*NPIN-1:0] tmr_pin_oe,
    output logic irq
);

    // ========================================================================
    // state
    ebt_state_type st_ff;
    ebt_state_type nxt_st;
    logic [NSRC-1:0] src_edge;
    logic [NTMR-1:0] src_tick;
    logic [NTMR-1:0] pre_tick;
    logic [NTMR-1:0] scaled_tick;
    logic [NTMR-1:0] ev;

    // ========================================================================
    // next state
    always_comb
    begin
        ebt_tmr_type t;
        logic [3:0] code;
        logic [2:0] idx;
        logic [5:0] lim;
        logic [7:0] top;
        logic [7:0] ncnt;
        logic [NTMR-1:0] clr;
        t = '0;
        code = '0;
        idx = '0;
        lim = '0;
        top = '0;
        ncnt = '0;
        clr = '0;
        nxt_st = st_ff;
        nxt_st.rdata = '0;
        src_tick = '0;
        pre_tick = '0;
        scaled_tick = '0;
        ev = '0;

        // three-stage sampling; a rising change counts once stages two and three agree
        nxt_st.s1 = src_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        for (int k = 0; k < NSRC; k++)
        begin
            if (st_ff.s2[k] == st_ff.s3[k])
            begin
                nxt_st.filt[k] = st_ff.s2[k];
            end
        end
        src_edge = st_ff.s2 & st_ff.s3 & ~st_ff.filt;

        for (int i = 0; i < NTMR; i++)
        begin
            t = st_ff.tm[i];
            // source and prescale act at once: a stopped source must not
            // block its own replacement
            code = t.ctl[CTL_SRC_MSB:CTL_SRC_LSB];
            idx = 3'(code - SRC_FIRST_EXT);
            if (code == SRC_SYS) //RULE1
            begin
                src_tick[i] = 1'b1;
            end
            else if (code >= SRC_FIRST_EXT && code <= SRC_LAST_EXT)
            begin
                src_tick[i] = src_edge[idx]; //RULE1
            end

            // >= so that lowering a ratio never waits for a full wrap
            lim = PRE_LIM[t.scl[SCL_PRE_MSB:SCL_PRE_LSB]];
            pre_tick[i] = src_tick[i] && (t.pre >= lim); //RULE4
            if (src_tick[i])
            begin
                nxt_st.tm[i].pre = pre_tick[i] ? 6'h00 : 6'(t.pre + 6'h01);
            end
            scaled_tick[i] = pre_tick[i] &&
                (t.sc >= t.scl[SCL_DIV_MSB:0]); //RULE5
            if (pre_tick[i])
            begin
                nxt_st.tm[i].sc = scaled_tick[i] ? 5'h00 :
                    5'(t.sc + 5'h01);
            end

            if (scaled_tick[i])
            begin
                // shadowed settings move over only on the tick
                nxt_st.tm[i].act_mode = t.ctl[CTL_MODE_BIT]; //RULE17
                nxt_st.tm[i].act_res = t.scl[SCL_RES_BIT]; //RULE10
                nxt_st.tm[i].act_osel = t.ctl[CTL_OSEL_MSB:CTL_OSEL_LSB];
                nxt_st.tm[i].act_bnd = t.bnd; //RULE8
                top = t.scl[SCL_RES_BIT] ? PWM6_TOP : PWM8_TOP; //RULE12 RULE15
                ncnt = t.cnt;
                if (t.ld_pend)
                begin
                    ncnt = t.ld_val; //RULE6
                    nxt_st.tm[i].ld_pend = 1'b0;
                end
                else if (!t.ctl[CTL_MODE_BIT]) //RULE9
                begin
                    if (t.cnt >= t.bnd) //RULE7
                    begin
                        ncnt = 8'h00;
                        nxt_st.tm[i].wout = ~t.wout; //RULE11 RULE16
                        ev[i] = 1'b1; //RULE16
                    end
                    else
                    begin
                        ncnt = 8'(t.cnt + 8'h01); //RULE6
                    end
                end
                else
                begin
                    if (t.cnt >= top)
                    begin
                        ncnt = 8'h00;
                        ev[i] = 1'b1;
                    end
                    else
                    begin
                        ncnt = 8'(t.cnt + 8'h01);
                    end
                end
                if (t.ctl[CTL_MODE_BIT])
                begin
                    // high for bound+1 ticks; a bound at top stays high
                    nxt_st.tm[i].wout = (ncnt <= t.bnd); //RULE14 RULE15
                end
                nxt_st.tm[i].cnt = ncnt;
            end

            // register writes land after tick handling, so a count write
            // in a tick cycle still waits for the next tick
            if (bus_req.wr && !bus_req.addr[3] && (bus_req.addr[2] == i[0]))
            begin
                unique case (bus_req.addr[1:0])
                    REG_CTL: nxt_st.tm[i].ctl = bus_req.wdata & CTL_RW_MASK;
                    REG_SCL: nxt_st.tm[i].scl = bus_req.wdata;
                    REG_CNT:
                    begin
                        nxt_st.tm[i].ld_pend = 1'b1; //RULE17
                        nxt_st.tm[i].ld_val = bus_req.wdata;
                    end
                    REG_BND: nxt_st.tm[i].bnd = bus_req.wdata;
                endcase
            end
        end

        // sticky events, write one to clear, a new event wins
        if (bus_req.wr && bus_req.addr == OFS_IRQ_STAT)
        begin
            clr = bus_req.wdata[NTMR-1:0];
        end
        nxt_st.stat = (st_ff.stat & ~clr) | ev;
        if (bus_req.wr && bus_req.addr == OFS_IRQ_MASK)
        begin
            nxt_st.mask = bus_req.wdata[NTMR-1:0];
        end

        if (bus_req.rd)
        begin
            if (!bus_req.addr[3])
            begin
                t = st_ff.tm[bus_req.addr[2]];
                unique case (bus_req.addr[1:0])
                    REG_CTL: nxt_st.rdata = t.ctl;
                    REG_SCL: nxt_st.rdata = t.scl;
                    REG_CNT: nxt_st.rdata = t.cnt; //RULE6
                    REG_BND: nxt_st.rdata = t.bnd;
                endcase
            end
            else if (bus_req.addr == OFS_IRQ_STAT)
            begin
                nxt_st.rdata = {{(DW-NTMR){1'b0}}, st_ff.stat};
            end
            else if (bus_req.addr == OFS_IRQ_MASK)
            begin
                nxt_st.rdata = {{(DW-NTMR){1'b0}}, st_ff.mask};
            end
        end
    end

    // ========================================================================
    // registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_ff <= ST_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ========================================================================
    // outputs
    assign bus_rdata = st_ff.rdata;
    assign irq = |(st_ff.stat & st_ff.mask);

    // pins of timer g are g*3+0..2; select code 0 leaves all three released
    for (genvar g = 0; g < NTMR; g++)
    begin : g_pin
        for (genvar p = 0; p < NPIN; p++)
        begin : g_bit
            // forced drive ignores the port direction setting
            assign tmr_pin_oe[g*NPIN+p] =
                (st_ff.tm[g].act_osel == 2'(p + 1)); //RULE2 RULE3 RULE13
            assign tmr_pin_o[g*NPIN+p] =
                tmr_pin_oe[g*NPIN+p] & st_ff.tm[g].wout; //RULE2 RULE13
        end
    end

    // ========================================================================
    // checks
    for (genvar g = 0; g < NTMR; g++)
    begin : g_chk
        AST_SRC_STOP: assert property ( //RULE1
            @(posedge clk) disable iff (sys_rst)
            (st_ff.tm[g].ctl[CTL_SRC_MSB:CTL_SRC_LSB] == SRC_STOP)
            |=> $stable(st_ff.tm[g].pre))
            else $error("prescaler moved with source stopped");

        AST_PIN_DRIVE: assert property ( //RULE3
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ctl[CTL_OSEL_MSB:CTL_OSEL_LSB]
                != 2'h0)
            |=> (|tmr_pin_oe[g*NPIN +: NPIN]))
            else $error("selected pin not driven");

        AST_PRE_STEP: assert property ( //RULE4
            @(posedge clk) disable iff (sys_rst)
            (src_tick[g] && !pre_tick[g])
            |=> (st_ff.tm[g].pre == 6'($past(st_ff.tm[g].pre) + 6'h01)))
            else $error("prescaler did not step");

        AST_SCALE_BOUND: assert property ( //RULE5
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && $stable(st_ff.tm[g].scl))
            |=> (st_ff.tm[g].sc == 5'h00))
            else $error("scaler not cleared at tick");

        AST_COUNT_UP: assert property ( //RULE6
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && !st_ff.tm[g].ld_pend && !ev[g])
            |=> (st_ff.tm[g].cnt == 8'($past(st_ff.tm[g].cnt) + 8'h01)))
            else $error("counter did not count up");

        AST_PERIOD_WRAP: assert property ( //RULE7
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && !st_ff.tm[g].ld_pend &&
                !st_ff.tm[g].ctl[CTL_MODE_BIT] &&
                st_ff.tm[g].cnt == st_ff.tm[g].bnd)
            |=> (st_ff.tm[g].cnt == 8'h00) && st_ff.stat[g] &&
                (st_ff.tm[g].wout != $past(st_ff.tm[g].wout)))
            else $error("period wrap wrong");

        AST_PERIOD_HOLD: assert property ( //RULE11
            @(posedge clk) disable iff (sys_rst)
            (!ev[g] && !st_ff.tm[g].ctl[CTL_MODE_BIT])
            |=> $stable(st_ff.tm[g].wout))
            else $error("output changed without a wrap");

        AST_PWM_DUTY: assert property ( //RULE14
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ctl[CTL_MODE_BIT])
            |=> (st_ff.tm[g].wout ==
                (st_ff.tm[g].cnt <= st_ff.tm[g].act_bnd)))
            else $error("pwm output disagrees with duty");

        AST_PWM6_TOP: assert property ( //RULE15
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ctl[CTL_MODE_BIT] &&
                st_ff.tm[g].scl[SCL_RES_BIT] && !st_ff.tm[g].ld_pend &&
                st_ff.tm[g].cnt == PWM6_TOP)
            |=> (st_ff.tm[g].cnt == 8'h00))
            else $error("6-bit pwm did not wrap at 63");

        AST_SHADOW: assert property ( //RULE17
            @(posedge clk) disable iff (sys_rst)
            (!scaled_tick[g]) |=> $stable(st_ff.tm[g].act_bnd) &&
                $stable(st_ff.tm[g].act_mode) &&
                $stable(st_ff.tm[g].act_osel))
            else $error("setting applied between ticks");

        AST_PIN_ONEHOT: assert property ( //RULE2
            @(posedge clk) disable iff (sys_rst)
            $onehot0(tmr_pin_oe[g*NPIN +: NPIN]))
            else $error("more than one output pin driven");

        AST_PRE_WRAP: assert property ( //RULE4
            @(posedge clk) disable iff (sys_rst)
            pre_tick[g] |=> (st_ff.tm[g].pre == 6'h00))
            else $error("prescaler not cleared at its limit");

        // a count write in the tick cycle re-arms the load, so leave it out
        AST_COUNT_LOAD: assert property ( //RULE6
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ld_pend &&
                !(bus_req.wr && bus_req.addr == {2'(g), REG_CNT}))
            |=> (st_ff.tm[g].cnt == $past(st_ff.tm[g].ld_val)) &&
                !st_ff.tm[g].ld_pend)
            else $error("count write not loaded at the tick");

        AST_PWM8_TOP: assert property ( //RULE12
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ctl[CTL_MODE_BIT] &&
                !st_ff.tm[g].scl[SCL_RES_BIT] && !st_ff.tm[g].ld_pend &&
                st_ff.tm[g].cnt == PWM8_TOP)
            |=> (st_ff.tm[g].cnt == 8'h00))
            else $error("8-bit pwm did not wrap at 255");

        AST_EVENT_SET: assert property ( //RULE16
            @(posedge clk) disable iff (sys_rst)
            ev[g] |=> st_ff.stat[g])
            else $error("event lost against a clear");

        AST_PWM_FULL: assert property ( //RULE14
            @(posedge clk) disable iff (sys_rst)
            (scaled_tick[g] && st_ff.tm[g].ctl[CTL_MODE_BIT] &&
                st_ff.tm[g].bnd == PWM8_TOP)
            |=> st_ff.tm[g].wout)
            else $error("bound 255 did not hold the output high");

        AST_SHADOW_LOAD: assert property ( //RULE17
            @(posedge clk) disable iff (sys_rst)
            scaled_tick[g] |=>
                (st_ff.tm[g].act_bnd == $past(st_ff.tm[g].bnd)) &&
                (st_ff.tm[g].act_mode ==
                    $past(st_ff.tm[g].ctl[CTL_MODE_BIT])))
            else $error("settings not taken over at the tick");

        AST_STOP_TICK: assert property ( //RULE1
            @(posedge clk) disable iff (sys_rst)
            (st_ff.tm[g].ctl[CTL_SRC_MSB:CTL_SRC_LSB] == SRC_STOP ||
                st_ff.tm[g].ctl[CTL_SRC_MSB:CTL_SRC_LSB] > SRC_LAST_EXT)
            |-> !src_tick[g])
            else $error("stopped source produced a tick");
    end

    AST_IRQ_LEVEL: assert property (
        @(posedge clk) disable iff (sys_rst)
        (|(ev & st_ff.mask)) && !bus_req.wr |=> irq)
        else $error("event did not raise interrupt");

    AST_READ_SLOT: assert property (
        @(posedge clk) disable iff (sys_rst)
        (!bus_req.rd) |=> (bus_rdata == 8'h00))
        else $error("read data outside its slot");

    AST_STAT_CLEAR: assert property (
        @(posedge clk) disable iff (sys_rst)
        (bus_req.wr && bus_req.addr == OFS_IRQ_STAT && !(|ev))
        |=> ((st_ff.stat & $past(bus_req.wdata[NTMR-1:0])) == '0))
        else $error("status bit survived a write of one");

endmodule

/* File: dv/ebt_load_model.sv */
// load on the six timer pins: a pull-down wherever no driver is on
// assumes the bench clock; counts high samples and rising edges of one pad
`timescale 1ns/10ps

module ebt_load_model
    import ebt_pkg::*;
(
    input wire logic clk,
    input wire logic clr,
    input wire logic [2:0] sel,
    input wire logic [NTMR*NPIN-1:0] pin_o,
    input wire logic [NTMR*NPIN-1:0] pin_oe,
    output logic [NTMR*NPIN-1:0] pad,
    output logic [15:0] hi_cnt,
    output logic [15:0] rise_cnt
);
    logic prev;

    // ========================================================================
    // pad level and counters
    // released pad sinks to the pull-down, never keeps the last level
    assign pad = pin_oe & pin_o;

    always_ff @(posedge clk)
    begin
        prev <= pad[sel];
        if (clr)
        begin
            hi_cnt <= 16'h0;
            rise_cnt <= 16'h0;
        end
        else
        begin
            hi_cnt <= hi_cnt + 16'(pad[sel]);
            rise_cnt <= rise_cnt + 16'(pad[sel] & ~prev);
        end
    end
endmodule

/* File: dv/ebt_timer_tb.sv */
// self-checking bench for the dual 8-bit timer
// assumes the load model on the pins and a plain one-cycle register port
`timescale 1ns/10ps

module ebt_timer_tb
    import ebt_pkg::*;
;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    ebt_bus_req_type bus_req = '0;
    logic [DW-1:0] bus_rdata;
    logic [NSRC-1:0] src_in = '0;
    logic [NTMR*NPIN-1:0] tmr_pin_o, tmr_pin_oe, pad;
    logic irq;
    logic clr = 1'b0;
    logic [2:0] sel = 3'h0;
    logic [15:0] hi_cnt, rise_cnt;
    logic [7:0] ph = 8'h0;
    int bad_count = 0;
    int n_tests = 0;

    // ========================================================================
    // clock, slow sources, instances
    always #4 clk = ~clk;

    // sources of periods 8,8,16,16,32,32,64 clocks, slow enough to filter
    always @(posedge clk)
    begin
        ph <= ph + 8'h1;
        src_in <= {ph[5], ph[4], ph[4], ph[3], ph[3], ph[2], ph[2]};
    end

    ebt_timer ebt_timer_inst (.clk(clk), .sys_rst(sys_rst),
        .bus_req(bus_req), .bus_rdata(bus_rdata), .src_in(src_in),
        .tmr_pin_o(tmr_pin_o), .tmr_pin_oe(tmr_pin_oe), .irq(irq));

    ebt_load_model ebt_load_model_inst (.clk(clk), .clr(clr), .sel(sel),
        .pin_o(tmr_pin_o), .pin_oe(tmr_pin_oe), .pad(pad),
        .hi_cnt(hi_cnt), .rise_cnt(rise_cnt));

    // ========================================================================
    // shared tasks
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clk);
        bus_req.rd <= 1'b0;
        @(posedge clk);
        d = bus_rdata;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(16'(d), 16'(exp));
    endtask

    // ctl goes last so a new source starts with the new ratios in place
    task automatic cfg(input logic [3:0] b, input logic [7:0] c,
        input logic [7:0] s, input logic [7:0] k);
        wr({b[3:2], REG_SCL}, s);
        wr({b[3:2], REG_BND}, k);
        wr({b[3:2], REG_CTL}, c);
    endtask

    // settle first: external sources pass a synchroniser and a filter
    task automatic measure(input logic [2:0] p, input int w,
        input logic [15:0] eh, input logic [15:0] er);
        repeat (600) @(posedge clk);
        sel <= p;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (w) @(posedge clk);
        #1;
        chk(hi_cnt, eh);
        chk(rise_cnt, er);
    endtask

    // ========================================================================
    // scenarios
    task automatic t_regs();
        for (int i = 0; i < 10; i++)
            rdchk(4'(i), 8'h00);
        wr(OFS_TMR0, 8'h0f);
        rdchk(OFS_TMR0, 8'h0e);
        wr(4'h1, 8'hff);
        rdchk(4'h1, 8'hff);
        wr(4'h3, 8'ha5);
        rdchk(4'h3, 8'ha5);
        wr(4'ha, 8'hff);
        rdchk(4'ha, 8'h00);
    endtask

    task automatic t_period();
        for (int k = 1; k < 4; k++)
        begin
            cfg(OFS_TMR0, 8'h10 | 8'(k << 2), 8'h00, 8'h01);
            measure(3'(k - 1), 64, 16'd32, 16'd16);
            chk(16'(tmr_pin_oe), 16'(1 << (k - 1)));
        end
    endtask

    task automatic t_ratio();
        logic [7:0] sc [6] = '{8'h01, 8'h21, 8'h41, 8'h61, 8'h1f, 8'h00};
        logic [7:0] bd [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0f};
        logic [15:0] er [6] = '{16'd256, 16'd64, 16'd16, 16'd4, 16'd16,
            16'd32};
        for (int i = 0; i < 6; i++)
        begin
            cfg(OFS_TMR0, 8'h14, sc[i], bd[i]);
            measure(3'h0, 1024, 16'd512, er[i]);
        end
    endtask

    task automatic t_src();
        logic [15:0] er [7] = '{16'd64, 16'd64, 16'd32, 16'd32, 16'd16,
            16'd16, 16'd8};
        for (int c = 2; c < 9; c++)
        begin
            cfg(OFS_TMR0, {4'(c), 4'h4}, 8'h00, 8'h00);
            measure(3'h0, 1024, 16'd512, er[c - 2]);
        end
    endtask

    task automatic t_pwm();
        logic [7:0] sc [4] = '{8'h00, 8'h00, 8'h80, 8'h80};
        logic [7:0] bd [4] = '{8'h3f, 8'hff, 8'h1f, 8'h00};
        logic [15:0] eh [4] = '{16'd128, 16'd512, 16'd256, 16'd8};
        logic [15:0] er [4] = '{16'd2, 16'd0, 16'd8, 16'd8};
        for (int i = 0; i < 4; i++)
        begin
            cfg(OFS_TMR0, 8'h16, sc[i], bd[i]);
            measure(3'h0, 512, eh[i], er[i]);
        end
    endtask

    task automatic t_second();
        cfg(OFS_TMR1, 8'h1c, 8'h00, 8'h01);
        measure(3'h5, 64, 16'd32, 16'd16);
        chk(16'(tmr_pin_oe[5:3]), 16'h4);
    endtask

    task automatic t_count();
        logic [7:0] a, b;
        cfg(OFS_TMR0, 8'h10, 8'h00, 8'hff);
        wr(4'h2, 8'h10);
        rd(4'h2, a);
        rd(4'h2, b);
        chk(16'(b - a), 16'h3);
        chk(16'(a >= 8'h10 && a < 8'h18), 16'h1);
        wr(4'h3, 8'h03);
        for (int i = 0; i < 8; i++)
        begin
            rd(4'h2, a);
            chk(16'(a <= 8'h03), 16'h1);
        end
    endtask

    task automatic t_irq();
        rdchk(OFS_IRQ_STAT, 8'h03);
        chk(16'(irq), 16'h0);
        wr(OFS_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        chk(16'(irq), 16'h1);
        cfg(OFS_TMR0, 8'h00, 8'h00, 8'h00);
        cfg(OFS_TMR1, 8'h00, 8'h00, 8'h00);
        repeat (8) @(posedge clk);
        wr(OFS_IRQ_STAT, 8'h01);
        rdchk(OFS_IRQ_STAT, 8'h02);
        chk(16'(irq), 16'h0);
        wr(OFS_IRQ_MASK, 8'h02);
        repeat (2) @(posedge clk);
        chk(16'(irq), 16'h1);
        wr(OFS_IRQ_STAT, 8'h02);
        repeat (2) @(posedge clk);
        chk(16'(irq), 16'h0);
    endtask

    // ========================================================================
    // main sequence and watchdog
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_regs();
        t_period();
        t_ratio();
        t_src();
        t_pwm();
        t_second();
        t_count();
        t_irq();
        end_sim();
    end

    // whole run needs about 30000 cycles
    initial
    begin
        repeat (60000) @(posedge clk);
        bad_count++;
        $display("BAD t=%0t watchdog expired", $time);
        end_sim();
    end
endmodule
